/* File: hw/cpg_regs.sv */
`timescale 1ns/1ps
`include "cpg_defines.svh"
// Notes on behaviour
// (RULE1) Block on only when both disables zero
// (RULE2) First extra power-down bits reset to one, except unused bit 8 (reset zero)
// (RULE3) Second extra power-down: sixteen bits reset one
// (RULE4) General register: bits 13, 7, reset zero
// (RULE5) Seven fast power-up bits, reset zero
// (RULE6) Hi-fi clock divide from bits 14:12
// (RULE7) Voice clock divide from bits 11:8
// (RULE8) Link clock external when bit 7 set
// (RULE9) Aux converter clock divide table, bits 5:3
// (RULE10) Bits 2 and 1 double inputs B, A
// (RULE11) Bit 0 picks clock input A or B
// (RULE12) PLL N divider, codes 0 and 1 divide one
// (RULE13) PLL low-frequency and sigma-delta enable bits
// (RULE14) PLL input predivide by one, two, four
// (RULE15) Pager stores data nibble into addressed page
// (RULE16) Direction one input, bits 9-15 always input
// (RULE17) Polarity or drive type per direction
// (RULE18) Sticky latches active input, else follows
// (RULE19) Interrupt only with wake bit set
// (RULE20) Status read; writing zero clears sticky bits
// (RULE21) Bits 15-9 virtual, 8-1 physical pins
// (RULE22) Pin function one gives GPIO control
// (RULE23) Bit 15 disables touch converter, reset one
// (RULE24) Standard power bits 14-8 reset one
// (RULE25) Middle divider codes divide by code plus one
// (RULE26) Interrupt while waking status bit is active
module cpg_regs
   import cpg_pkg::*;
(
   input  wire logic                 sys_clk_in,
   input  wire logic                 reset_in,
   input  wire cpg_pkg::cpg_apb_req_t apb_in,
   output logic [31:0]               prdata_out,
   output logic                      pready_out,
   output logic                      pslverr_out,
   input  wire logic [8:1]           gpio_pin_in,
   output logic [8:1]                gpio_pin_out,
   output logic [8:1]                gpio_pin_oe_out,
   output logic [8:1]                gpio_alt_function_out,
   input  wire logic [15:9]          virtual_signal_in,
   output logic                      irq_out,
   output cpg_pkg::cpg_power_t       power_out,
   output cpg_pkg::cpg_clock_t       clock_out,
   output logic                      spatial_enhance_en_out,
   output logic                      digital_loopback_en_out,
   output logic [6:0]                fast_powerup_out,
   output logic                      hifi_clk_en_out,
   output logic                      voice_clk_en_out,
   output logic                      aux_adc_clk_en_out
);
   import cpg_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Register state
   logic [15:0] pwr_std_q, pwr_std_d;
   logic [15:0] xpd_a_q, xpd_a_d;
   logic [15:0] xpd_b_q, xpd_b_d;
   logic [15:0] gp_q, gp_d;
   logic [15:0] fast_q, fast_d;
   logic [15:0] clk_q, clk_d;
   logic [15:0] pll_q, pll_d;
   logic [15:0] dir_q, dir_d;
   logic [15:0] pol_q, pol_d;
   logic [15:0] sticky_q, sticky_d;
   logic [15:0] wake_q, wake_d;
   logic [15:0] status_q, status_d;
   logic [15:0] outlvl_q, outlvl_d;
   logic [15:0] func_q, func_d;
   logic [3:0]  page_q [8];
   logic [3:0]  page_d [8];
   logic [31:0] prdata_q, prdata_d;
   logic        slverr_q, slverr_d;
   logic        irq_q, irq_d;
   logic [8:1]  pin_meta_q, pin_sync_q;

   logic        wr_en;
   logic        setup;
   logic        addr_ok;
   logic [7:0]  idx;
   logic [15:0] wd;
   logic [15:0] raw_in;
   logic [15:0] active;
   logic [15:0] dir_eff;
   logic [15:0] rd_val;
   logic        rd_hit;
   logic [2:0]  pg_addr;

   assign idx     = apb_in.paddr[9:2];
   assign addr_ok = (apb_in.paddr[1:0] == 2'b00) &&
                    (apb_in.paddr[11:10] == 2'b00);
   assign setup   = apb_in.psel && !apb_in.penable;
   assign wr_en   = apb_in.psel && apb_in.penable && apb_in.pwrite &&
                    addr_ok && rd_hit;
   assign wd      = apb_in.pwdata[15:0];
   assign pg_addr = wd[`CPG_PLL_PGA_HI:`CPG_PLL_PGA_LO];

   // Zero-wait slave: read data is captured in the setup cycle
   assign pready_out  = apb_in.psel && apb_in.penable;
   assign prdata_out  = prdata_q;
   assign pslverr_out = slverr_q && pready_out;

   ////////////////////////////////////////////////////////////////////////
   // Read mux and decode
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 16'h0000;
      case (idx)
         `CPG_IDX_PWR_STD:     rd_val = pwr_std_q;
         `CPG_IDX_XPD_A:       rd_val = xpd_a_q;
         `CPG_IDX_XPD_B:       rd_val = xpd_b_q;
         `CPG_IDX_GP_CTRL:     rd_val = gp_q;
         `CPG_IDX_FAST_PU:     rd_val = fast_q;
         `CPG_IDX_CLK_DIV:     rd_val = clk_q;
         `CPG_IDX_PLL_CTRL:    rd_val = pll_q;
         `CPG_IDX_GPIO_DIR:    rd_val = dir_eff;
         `CPG_IDX_GPIO_POL:    rd_val = pol_q;
         `CPG_IDX_GPIO_STICKY: rd_val = sticky_q;
         `CPG_IDX_GPIO_WAKE:   rd_val = wake_q;
         `CPG_IDX_GPIO_STATUS: rd_val = status_q;   // [RULE20]
         `CPG_IDX_GPIO_FUNC:   rd_val = func_q;
         default:              rd_hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // GPIO input conditioning
   // Virtual bits come from on-chip logic, so they are not synchronised
   assign dir_eff = dir_q | `CPG_MSK_GPIO_VIRT;             // [RULE16]
   assign raw_in  = {virtual_signal_in,                      // [RULE21]
                     pin_sync_q & func_q[8:1], 1'b0};        // [RULE22]
   assign active  = ~(raw_in ^ pol_q) & dir_eff &            // [RULE17]
                    `CPG_MSK_GPIO;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      pwr_std_d = pwr_std_q;
      xpd_a_d   = xpd_a_q;
      xpd_b_d   = xpd_b_q;
      gp_d      = gp_q;
      fast_d    = fast_q;
      clk_d     = clk_q;
      pll_d     = pll_q;
      dir_d     = dir_q;
      pol_d     = pol_q;
      sticky_d  = sticky_q;
      wake_d    = wake_q;
      outlvl_d  = outlvl_q;
      func_d    = func_q;
      for (int p = 0; p < 8; p++) begin
         page_d[p] = page_q[p];
      end
      prdata_d  = prdata_q;
      slverr_d  = slverr_q;
      if (setup) begin
         prdata_d = {16'h0000, rd_val};
         slverr_d = !(addr_ok && rd_hit);
      end
      if (wr_en) begin
         case (idx)
            `CPG_IDX_PWR_STD:     pwr_std_d = wd & `CPG_MSK_PWR_STD;
            `CPG_IDX_XPD_A:       xpd_a_d   = wd & `CPG_MSK_XPD_A;
            `CPG_IDX_XPD_B:       xpd_b_d   = wd & `CPG_MSK_XPD_B;
            `CPG_IDX_GP_CTRL:     gp_d      = wd & `CPG_MSK_GP_CTRL;
            `CPG_IDX_FAST_PU:     fast_d    = wd & `CPG_MSK_FAST_PU;
            `CPG_IDX_CLK_DIV:     clk_d     = wd & `CPG_MSK_CLK_DIV;
            `CPG_IDX_PLL_CTRL: begin
               pll_d           = wd & `CPG_MSK_PLL_CTRL;
               page_d[pg_addr] =                          // [RULE15]
                  wd[`CPG_PLL_PGD_HI:`CPG_PLL_PGD_LO];
            end
            `CPG_IDX_GPIO_DIR:    dir_d     = wd & `CPG_MSK_GPIO;
            `CPG_IDX_GPIO_POL:    pol_d     = wd & `CPG_MSK_GPIO;
            `CPG_IDX_GPIO_STICKY: sticky_d  = wd & `CPG_MSK_GPIO;
            `CPG_IDX_GPIO_WAKE:   wake_d    = wd & `CPG_MSK_GPIO;
            `CPG_IDX_GPIO_STATUS: outlvl_d  = wd & `CPG_MSK_GPIO;
            `CPG_IDX_GPIO_FUNC:   func_d    = wd & `CPG_MSK_GPIO_FUNC;
            default:              slverr_d  = slverr_q;
         endcase
      end
   end

   // Status: new activity wins over a clearing write in the same cycle
   always_comb begin
      logic [15:0] clr;
      clr = 16'h0000;
      if (wr_en && idx == `CPG_IDX_GPIO_STATUS) begin
         clr = ~wd;                                        // [RULE20]
      end
      for (int i = 0; i < 16; i++) begin
         if (!dir_eff[i]) begin
            status_d[i] = outlvl_q[i];
         end else if (sticky_q[i]) begin
            status_d[i] = (status_q[i] & ~clr[i]) | active[i]; // [RULE18]
         end else begin
            status_d[i] = active[i];                       // [RULE18]
         end
      end
      status_d = status_d & `CPG_MSK_GPIO;
      irq_d    = |(status_q & wake_q & dir_eff);           // [RULE19] [RULE26]
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         pwr_std_q  <= `CPG_RST_PWR_STD;                   // [RULE24]
         xpd_a_q    <= `CPG_RST_XPD_A;                     // [RULE2] [RULE23]
         xpd_b_q    <= `CPG_RST_XPD_B;                     // [RULE3]
         gp_q       <= `CPG_RST_GP_CTRL;                   // [RULE4]
         fast_q     <= `CPG_RST_FAST_PU;                   // [RULE5]
         clk_q      <= `CPG_RST_CLK_DIV;                   // [RULE8]
         pll_q      <= `CPG_RST_PLL_CTRL;
         dir_q      <= `CPG_RST_GPIO_DIR;                  // [RULE16]
         pol_q      <= `CPG_RST_GPIO_POL;                  // [RULE17]
         sticky_q   <= `CPG_RST_GPIO_STICKY;               // [RULE18]
         wake_q     <= `CPG_RST_GPIO_WAKE;                 // [RULE19]
         status_q   <= 16'h0000;
         outlvl_q   <= 16'h0000;
         func_q     <= `CPG_RST_GPIO_FUNC;                 // [RULE22]
         for (int p = 0; p < 8; p++) begin
            page_q[p] <= 4'h0;
         end
         prdata_q   <= 32'h0000_0000;
         slverr_q   <= 1'b0;
         irq_q      <= 1'b0;
         pin_meta_q <= 8'h00;
         pin_sync_q <= 8'h00;
      end else begin
         pwr_std_q  <= pwr_std_d;
         xpd_a_q    <= xpd_a_d;
         xpd_b_q    <= xpd_b_d;
         gp_q       <= gp_d;
         fast_q     <= fast_d;
         clk_q      <= clk_d;
         pll_q      <= pll_d;
         dir_q      <= dir_d;
         pol_q      <= pol_d;
         sticky_q   <= sticky_d;
         wake_q     <= wake_d;
         status_q   <= status_d;
         outlvl_q   <= outlvl_d;
         func_q     <= func_d;
         for (int p = 0; p < 8; p++) begin
            page_q[p] <= page_d[p];
         end
         prdata_q   <= prdata_d;
         slverr_q   <= slverr_d;
         irq_q      <= irq_d;
         pin_meta_q <= gpio_pin_in;
         pin_sync_q <= pin_meta_q;
      end
   end

   assign irq_out = irq_q;

   ////////////////////////////////////////////////////////////////////////
   // Pin drive: open drain only ever pulls low
   always_comb begin
      for (int i = 1; i <= 8; i++) begin
         gpio_pin_out[i]          = outlvl_q[i];
         gpio_pin_oe_out[i]       = func_q[i] && !dir_q[i] &&   // [RULE22]
                                    (!pol_q[i] || !outlvl_q[i]); // [RULE17]
         gpio_alt_function_out[i] = !func_q[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power gating: extra bits pair with a standard power bit
   function automatic logic [2:0] std_for_a(input int b);
      case (b)
         9:                std_for_a = 3'd5;   // PLL with internal clock
         7, 6:             std_for_a = 3'd1;   // Stereo DAC
         5, 4:             std_for_a = 3'd0;   // Stereo ADC
         3, 2, 1, 0:       std_for_a = 3'd2;   // Mixers
         default:          std_for_a = 3'd3;   // Analogue
      endcase
   endfunction

   function automatic logic [2:0] std_for_b(input int b);
      if (b >= 7 && b <= 13) begin
         std_for_b = 3'd6;                     // Output amplifiers
      end else begin
         std_for_b = 3'd2;                     // Input stages
      end
   endfunction

   logic [6:0] std_off;
   assign std_off = pwr_std_q[`CPG_STD_LO +: 7];
   localparam logic [15:0] XA_IMPL = `CPG_MSK_XPD_A; // Bit 8 has no block

   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_pwr
         assign power_out.xa_on[g] = !xpd_a_q[g] &&       // [RULE1]
                                     !std_off[std_for_a(g)] &&
                                     XA_IMPL[g];
         assign power_out.xb_on[g] = !xpd_b_q[g] &&       // [RULE1]
                                     !std_off[std_for_b(g)];
      end
   endgenerate
   assign power_out.std_on = ~std_off;

   assign spatial_enhance_en_out  = gp_q[13];               // [RULE4]
   assign digital_loopback_en_out = gp_q[7];                // [RULE4]
   assign fast_powerup_out        = fast_q[6:0];            // [RULE5]

   ////////////////////////////////////////////////////////////////////////
   // Clock selection and PLL controls
   logic [31:0] page_word;
   logic [3:0]  n_code;
   always_comb begin
      for (int p = 0; p < 8; p++) begin
         page_word[4*p +: 4] = page_q[p];                  // [RULE15]
      end
   end
   assign n_code = pll_q[`CPG_PLL_N_HI:`CPG_PLL_N_LO];

   assign clock_out.link_clock_source     = clk_q[`CPG_CLK_SRC];  // [RULE8]
   assign clock_out.external_clock_select = clk_q[`CPG_CLK_MUX];  // [RULE11]
   assign clock_out.clock_in_a_double     = clk_q[`CPG_CLK_A_X2]; // [RULE10]
   assign clock_out.clock_in_b_double     = clk_q[`CPG_CLK_B_X2]; // [RULE10]
   assign clock_out.pll_n_div             = (n_code < 4'h2) ?     // [RULE12]
                                            4'h1 : n_code;
   assign clock_out.pll_low_freq_mode     = pll_q[`CPG_PLL_LF];   // [RULE13]
   assign clock_out.pll_sigma_delta_en    = pll_q[`CPG_PLL_SDM];  // [RULE13]
   assign clock_out.pll_prediv_factor     =                       // [RULE14]
      !pll_q[`CPG_PLL_PLL_PREDIV_ENABLE] ? 3'd1 :
      (pll_q[`CPG_PLL_DIVVAL] ? 3'd4 : 3'd2);
   assign clock_out.pll_k          = page_word[`CPG_PLL_K_HI:0];
   assign clock_out.pll_post_scale =
      page_word[`CPG_PLL_S_HI:`CPG_PLL_S_LO];

   ////////////////////////////////////////////////////////////////////////
   // Clock dividers as enable pulses from the system clock
   logic [4:0] div_val [3];
   logic [3:0] div_cnt_q [3];
   logic [3:0] div_cnt_d [3];
   logic [2:0] div_en_q, div_en_d;

   always_comb begin
      div_val[0] = 5'(clk_q[`CPG_CLK_HIFI_HI:`CPG_CLK_HIFI_LO]) // [RULE6]
                   + 5'd1;                                     // [RULE25]
      div_val[1] = 5'(clk_q[`CPG_CLK_VOICE_HI:`CPG_CLK_VOICE_LO]) // [RULE7]
                   + 5'd1;                                     // [RULE25]
      case (clk_q[`CPG_CLK_AUX_HI:`CPG_CLK_AUX_LO])             // [RULE9]
         3'd0:    div_val[2] = 5'd16;
         3'd1:    div_val[2] = 5'd12;
         3'd2:    div_val[2] = 5'd8;
         3'd3:    div_val[2] = 5'd6;
         3'd4:    div_val[2] = 5'd4;
         3'd5:    div_val[2] = 5'd3;
         3'd6:    div_val[2] = 5'd2;
         default: div_val[2] = 5'd1;
      endcase
   end

   generate
      for (g = 0; g < 3; g++) begin : g_div
         // Shortened divisor takes effect at once: a count already at or past it wraps on the next cycle
         always_comb begin
            if ({1'b0, div_cnt_q[g]} >= div_val[g] - 5'd1) begin
               div_cnt_d[g] = 4'h0;
               div_en_d[g]  = 1'b1;
            end else begin
               div_cnt_d[g] = div_cnt_q[g] + 4'h1;
               div_en_d[g]  = 1'b0;
            end
         end
         always_ff @(posedge sys_clk_in) begin
            if (reset_in) begin
               div_cnt_q[g] <= 4'h0;
               div_en_q[g]  <= 1'b0;
            end else begin
               div_cnt_q[g] <= div_cnt_d[g];
               div_en_q[g]  <= div_en_d[g];
            end
         end
      end
   endgenerate

   assign hifi_clk_en_out    = div_en_q[0];
   assign voice_clk_en_out   = div_en_q[1];
   assign aux_adc_clk_en_out = div_en_q[2];

endmodule

/* File: hw/cpg_defines.svh */
`ifndef CPG_DEFINES_SVH
`define CPG_DEFINES_SVH

// Register indices; byte address is four times the index
`define CPG_IDX_PWR_STD     8'h26
`define CPG_IDX_XPD_A       8'h3C
`define CPG_IDX_XPD_B       8'h3E
`define CPG_IDX_GP_CTRL     8'h40
`define CPG_IDX_FAST_PU     8'h42
`define CPG_IDX_CLK_DIV     8'h44
`define CPG_IDX_PLL_CTRL    8'h46
`define CPG_IDX_GPIO_DIR    8'h4C
`define CPG_IDX_GPIO_POL    8'h4E
`define CPG_IDX_GPIO_STICKY 8'h50
`define CPG_IDX_GPIO_WAKE   8'h52
`define CPG_IDX_GPIO_STATUS 8'h54
`define CPG_IDX_GPIO_FUNC   8'h56

// Reset values
`define CPG_RST_PWR_STD     16'h7F00
`define CPG_RST_XPD_A       16'hFEFF
`define CPG_RST_XPD_B       16'hFFFF
`define CPG_RST_GP_CTRL     16'h0000
`define CPG_RST_FAST_PU     16'h0000
`define CPG_RST_CLK_DIV     16'h0080
`define CPG_RST_PLL_CTRL    16'h0000
`define CPG_RST_GPIO_DIR    16'hFFFE
`define CPG_RST_GPIO_POL    16'hFFFE
`define CPG_RST_GPIO_STICKY 16'h0000
`define CPG_RST_GPIO_WAKE   16'h0000
`define CPG_RST_GPIO_FUNC   16'h01FE

// Writable bit masks
`define CPG_MSK_PWR_STD     16'h7F00
`define CPG_MSK_XPD_A       16'hFEFF
`define CPG_MSK_XPD_B       16'hFFFF
`define CPG_MSK_GP_CTRL     16'h2080
`define CPG_MSK_FAST_PU     16'h007F
`define CPG_MSK_CLK_DIV     16'h7FBF
`define CPG_MSK_PLL_CTRL    16'hFF7F
`define CPG_MSK_GPIO        16'hFFFE
`define CPG_MSK_GPIO_FUNC   16'h01FE
`define CPG_MSK_GPIO_VIRT   16'hFE00

// Field positions
`define CPG_STD_LO          8
`define CPG_CLK_HIFI_HI     14
`define CPG_CLK_HIFI_LO     12
`define CPG_CLK_VOICE_HI    11
`define CPG_CLK_VOICE_LO    8
`define CPG_CLK_SRC         7
`define CPG_CLK_AUX_HI      5
`define CPG_CLK_AUX_LO      3
`define CPG_CLK_B_X2        2
`define CPG_CLK_A_X2        1
`define CPG_CLK_MUX         0
`define CPG_PLL_N_HI        15
`define CPG_PLL_N_LO        12
`define CPG_PLL_LF          11
`define CPG_PLL_SDM         10
`define CPG_PLL_PLL_PREDIV_ENABLE      9
`define CPG_PLL_DIVVAL      8
`define CPG_PLL_PGA_HI      6
`define CPG_PLL_PGA_LO      4
`define CPG_PLL_PGD_HI      3
`define CPG_PLL_PGD_LO      0
`define CPG_PLL_K_HI        21
`define CPG_PLL_S_HI        28
`define CPG_PLL_S_LO        22

`endif

/* File: hw/cpg_pkg.sv */
package cpg_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } cpg_apb_req_t;

   typedef struct packed {
      logic [6:0]  std_on;
      logic [15:0] xa_on;
      logic [15:0] xb_on;
   } cpg_power_t;

   typedef struct packed {
      logic        link_clock_source;
      logic        external_clock_select;
      logic        clock_in_a_double;
      logic        clock_in_b_double;
      logic [3:0]  pll_n_div;
      logic        pll_low_freq_mode;
      logic        pll_sigma_delta_en;
      logic [2:0]  pll_prediv_factor;
      logic [21:0] pll_k;
      logic [6:0]  pll_post_scale;
   } cpg_clock_t;

endpackage

/* File: test/cpg_pin_model.sv */
`timescale 1ns/1ps
module cpg_pin_model (
   input  wire logic [8:1] pin_out_in,
   input  wire logic [8:1] pin_oe_in,
   input  wire logic [8:1] ext_level_in,
   input  wire logic [8:1] ext_drive_in,
   output logic [8:1]      pin_level_out
);
   // Released pins float to the weak pull-up, never hold the old level
   assign pin_level_out = (pin_oe_in & pin_out_in)
                        | (~pin_oe_in & ext_drive_in & ext_level_in)
                        | (~pin_oe_in & ~ext_drive_in);
endmodule

/* File: test/cpg_regs_checker.sv */
`timescale 1ns/1ps
module cpg_regs_checker
   import cpg_pkg::*;
(
   input wire logic                  sys_clk_in,
   input wire logic                  reset_in,
   input wire cpg_pkg::cpg_apb_req_t apb_in,
   input wire logic                  pready_out,
   input wire logic                  irq_out,
   input wire logic [8:1]            gpio_pin_oe_out,
   input wire logic [8:1]            gpio_alt_function_out,
   input wire cpg_pkg::cpg_power_t   power_out,
   input wire cpg_pkg::cpg_clock_t   clock_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   xa_pairing_a: assert property (
      power_out.xa_on[9] |-> power_out.std_on[5])
      else $error("block on while standard bit disabled");
   xb_pairing_a: assert property (
      power_out.xb_on[13] |-> power_out.std_on[6])
      else $error("output amp on while standard bit disabled");
   power_reset_a: assert property (
      $past(reset_in) |-> power_out == '0)
      else $error("block powered at reset");
   unused_bit_a: assert property (
      !power_out.xa_on[8]) else $error("unimplemented power bit on");
   clk_reset_a: assert property (
      $past(reset_in) |-> clock_out.link_clock_source
         && !clock_out.external_clock_select)
      else $error("clock source wrong at reset");
   n_div_a: assert property (
      clock_out.pll_n_div != 4'h0) else $error("divide by zero");
   prediv_a: assert property (
      clock_out.pll_prediv_factor inside {3'd1, 3'd2, 3'd4})
      else $error("bad predivide factor");
   irq_reset_a: assert property (
      $past(reset_in) |-> !irq_out) else $error("irq at reset");
   gpio_reset_a: assert property (
      $past(reset_in) |-> gpio_pin_oe_out == '0
         && gpio_alt_function_out == '0)
      else $error("gpio pins wrong at reset");
   ready_pair_a: assert property (
      pready_out == (apb_in.psel && apb_in.penable))
      else $error("pready outside access phase");
endmodule
bind cpg_regs cpg_regs_checker chk_i (.sys_clk_in(sys_clk_in),
   .reset_in(reset_in), .apb_in(apb_in), .pready_out(pready_out),
   .irq_out(irq_out), .gpio_pin_oe_out(gpio_pin_oe_out),
   .gpio_alt_function_out(gpio_alt_function_out),
   .power_out(power_out), .clock_out(clock_out));

/* File: test/cpg_regs_test.sv */
`timescale 1ns/1ps
`include "cpg_defines.svh"
module cpg_regs_test;
   import cpg_pkg::*;
   logic         sys_clk_in = 1'b0;
   logic         reset_in   = 1'b1;
   cpg_apb_req_t req        = '0;
   logic [15:9]  virt       = '0;
   logic [31:0]  prdata, rd;
   logic         pready, pslverr, irq, se, lb, hc, vc, ac, er;
   logic [8:1]   pin_lvl, pin_o, pin_oe, alt;
   logic [6:0]   fpu;
   cpg_power_t   pwr;
   cpg_clock_t   clk;
   int           failures = 0;
   int           samples_checked = 0;
   int           n, h, v, a;
   localparam logic [7:0] RIDX [12] = '{`CPG_IDX_PWR_STD, `CPG_IDX_XPD_A,
      `CPG_IDX_XPD_B, `CPG_IDX_GP_CTRL, `CPG_IDX_FAST_PU, `CPG_IDX_CLK_DIV,
      `CPG_IDX_PLL_CTRL, `CPG_IDX_GPIO_DIR, `CPG_IDX_GPIO_POL,
      `CPG_IDX_GPIO_STICKY, `CPG_IDX_GPIO_WAKE, `CPG_IDX_GPIO_FUNC};
   localparam logic [15:0] RVAL [12] = '{16'h7F00, 16'hFEFF, 16'hFFFF,
      16'h0000, 16'h0000, 16'h0080, 16'h0000, 16'hFFFE, 16'hFFFE,
      16'h0000, 16'h0000, 16'h01FE};
   localparam logic [15:0] DCFG [2] = '{16'h1F80, 16'h22B8};
   always #2.5 sys_clk_in = ~sys_clk_in;
   cpg_regs uut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .apb_in(req), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .gpio_pin_in(pin_lvl), .gpio_pin_out(pin_o),
      .gpio_pin_oe_out(pin_oe), .gpio_alt_function_out(alt),
      .virtual_signal_in(virt), .irq_out(irq), .power_out(pwr),
      .clock_out(clk), .spatial_enhance_en_out(se),
      .digital_loopback_en_out(lb), .fast_powerup_out(fpu),
      .hifi_clk_en_out(hc), .voice_clk_en_out(vc), .aux_adc_clk_en_out(ac));
   cpg_pin_model pins (.pin_out_in(pin_o), .pin_oe_in(pin_oe),
      .ext_level_in(8'h00), .ext_drive_in(8'h00), .pin_level_out(pin_lvl));
   ////////////////////////////////////////////////////////////////////
   // Index is a word number; byte address is four times it
   task automatic xfer(input logic w, input logic [7:0] i,
                       input logic [15:0] d);
      @(posedge sys_clk_in);
      req <= '{1'b1, 1'b0, w, {2'b00, i, 2'b00}, {16'h0000, d}};
      @(posedge sys_clk_in);
      req.penable <= 1'b1;
      n = 0;
      do @(posedge sys_clk_in); while (pready !== 1'b1 && ++n < 20);
      if (n >= 20) failures++;
      rd = prdata;
      er = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] i, input logic [15:0] m,
                       input logic [15:0] e);
      xfer(1'b0, i, 16'h0000);
      chk(rd & {16'hFFFF, m}, {16'h0000, e});
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #20000;
      failures++;
      report_and_stop;
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      for (int k = 0; k < 12; k++) rchk(RIDX[k], 16'hFFFF, RVAL[k]);
      $display("test reset done");
      xfer(1'b1, `CPG_IDX_PWR_STD, 16'h2000);
      xfer(1'b1, `CPG_IDX_XPD_A, 16'h0000);
      xfer(1'b1, `CPG_IDX_XPD_B, 16'h0000);
      @(posedge sys_clk_in);
      #1 chk(pwr.xa_on, 16'hFCFF);
      chk(pwr.xb_on, 16'hFFFF);
      chk(pwr.std_on, 7'h5F);
      xfer(1'b1, `CPG_IDX_PWR_STD, 16'h0000);
      @(posedge sys_clk_in);
      #1 chk(pwr.xa_on, 16'hFEFF);
      $display("test power done");
      for (int k = 3; k < 7; k++) xfer(1'b1, RIDX[k], 16'hFFFF);
      rchk(`CPG_IDX_GP_CTRL, 16'hFFFF, 16'h2080);
      rchk(`CPG_IDX_FAST_PU, 16'hFFFF, 16'h007F);
      rchk(`CPG_IDX_CLK_DIV, 16'hFFFF, 16'h7FBF);
      chk({se, lb, fpu}, 9'h1FF);
      chk({clk.link_clock_source, clk.external_clock_select,
           clk.clock_in_a_double, clk.clock_in_b_double}, 4'hF);
      xfer(1'b1, `CPG_IDX_CLK_DIV, 16'h0000);
      @(posedge sys_clk_in);
      #1 chk({clk.link_clock_source, clk.external_clock_select}, 0);
      xfer(1'b1, `CPG_IDX_PLL_CTRL, 16'hFF00);
      @(posedge sys_clk_in);
      #1 chk({clk.pll_n_div, clk.pll_low_freq_mode, clk.pll_sigma_delta_en,
           clk.pll_prediv_factor}, {4'hF, 2'b11, 3'd4});
      xfer(1'b1, `CPG_IDX_PLL_CTRL, 16'h1200);
      @(posedge sys_clk_in);
      #1 chk({clk.pll_n_div, clk.pll_prediv_factor}, 7'h0A);
      for (int p = 0; p < 8; p++)
         xfer(1'b1, `CPG_IDX_PLL_CTRL, {9'h000, 3'(p), 4'(p + 1)});
      @(posedge sys_clk_in);
      #1 chk(clk.pll_k, 22'h25_4321);
      chk(clk.pll_post_scale, 7'h1D);
      $display("test clock and pll done");
      xfer(1'b1, `CPG_IDX_GPIO_STICKY, 16'h8000);
      xfer(1'b1, `CPG_IDX_GPIO_WAKE, 16'h8000);
      virt <= 7'h40;
      repeat (3) @(posedge sys_clk_in);
      virt <= 7'h00;
      repeat (3) @(posedge sys_clk_in);
      #1 chk(irq, 1'b1);
      rchk(`CPG_IDX_GPIO_STATUS, 16'hC000, 16'h8000);
      xfer(1'b1, `CPG_IDX_GPIO_STATUS, 16'h0000);
      rchk(`CPG_IDX_GPIO_STATUS, 16'hC000, 16'h0000);
      chk(irq, 1'b0);
      virt <= 7'h20;
      repeat (3) @(posedge sys_clk_in);
      rchk(`CPG_IDX_GPIO_STATUS, 16'hC000, 16'h4000);
      chk(irq, 1'b0);
      virt <= 7'h00;
      repeat (3) @(posedge sys_clk_in);
      rchk(`CPG_IDX_GPIO_STATUS, 16'hC000, 16'h0000);
      $display("test gpio status done");
      // Pin 1 as output; open drain releases a high level
      xfer(1'b1, `CPG_IDX_GPIO_DIR, 16'hFFFC);
      xfer(1'b1, `CPG_IDX_GPIO_STATUS, 16'h0002);
      repeat (2) @(posedge sys_clk_in);
      #1 chk({pin_oe[2:1], pin_o[1]}, 3'b001);
      xfer(1'b1, `CPG_IDX_GPIO_POL, 16'hFFFC);
      repeat (2) @(posedge sys_clk_in);
      #1 chk({pin_oe[2:1], pin_o[1]}, 3'b011);
      xfer(1'b1, `CPG_IDX_GPIO_STATUS, 16'h0000);
      repeat (2) @(posedge sys_clk_in);
      #1 chk({pin_oe[2:1], pin_o[1], pin_lvl[1]}, 4'b0100);
      xfer(1'b1, `CPG_IDX_GPIO_FUNC, 16'h0000);
      @(posedge sys_clk_in);
      #1 chk(alt, 8'hFF);
      xfer(1'b1, `CPG_IDX_GPIO_DIR, 16'h0000);
      rchk(`CPG_IDX_GPIO_DIR, 16'hFFFF, 16'hFE00);
      xfer(1'b0, 8'h01, 16'h0000);
      chk(er, 1'b1);
      chk(rd, 32'h0000_0000);
      $display("test gpio pins done");
      for (int k = 0; k < 2; k++) begin
         xfer(1'b1, `CPG_IDX_CLK_DIV, DCFG[k]);
         repeat (40) @(posedge sys_clk_in);
         {h, v, a} = '0;
         repeat (48) begin
            @(posedge sys_clk_in);
            #1 h += hc;
            v += vc;
            a += ac;
         end
         chk(h, k ? 16 : 24);
         chk(v, k ? 16 : 3);
         chk(a, k ? 48 : 3);
      end
      $display("test dividers done");
      report_and_stop;
   end
endmodule
